// [rsc_pkg.sv]
// package of the reset source controller: register addresses, bit positions,
// reset values, timing constants and the cause and sequencer enumerations.
// assumes one 20 MHz clock shared by every module that imports it.
package rsc_pkg;

    localparam int CLK_MHZ = 20;

    // register addresses on the special function register port
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hFF;
    localparam logic [7:0] RESET_CAUSE_REGISTER_ADDR   = 8'hEF;

    // supply_monitor_control fields
    localparam int SMC_ON_BIT    = 7;
    localparam int SMC_ABOVE_BIT = 6;
    localparam int SMC_LEVEL_BIT = 5;
    localparam logic [4:0] SMC_UNUSED_READ = 5'h00;

    // reset_cause_register fields
    localparam int RCR_FLASH_BIT = 6;
    localparam int RCR_COMP_BIT  = 5;
    localparam int RCR_SOFT_BIT  = 4;
    localparam int RCR_WDT_BIT   = 3;
    localparam int RCR_MCD_BIT   = 2;
    localparam int RCR_POWER_BIT = 1;
    localparam int RCR_PIN_BIT   = 0;

    // reset values
    localparam logic       MONITOR_ON_RESET = 1'b1;
    localparam logic       LEVEL_RESET      = 1'b0;
    localparam logic       ENABLE_RESET     = 1'b0;
    localparam logic       WDT_EN_RESET     = 1'b1;
    localparam logic [7:0] FLAGS_RESET      = 8'h00;
    localparam logic [7:0] RDATA_RESET      = 8'h00;

    // timing
    localparam int RESET_HOLD_NS      = 1000;
    localparam int RESET_HOLD_CYCLES  = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int MCD_TIMEOUT_US     = 100;
    localparam int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
    localparam int WDT_DIVIDE         = 12;

    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_POWER,
        CAUSE_PIN,
        CAUSE_MCD,
        CAUSE_COMP,
        CAUSE_WDT,
        CAUSE_FLASH,
        CAUSE_SOFT
    } rsc_cause_type;

    typedef enum logic {
        SEQ_RUN,
        SEQ_HOLD
    } rsc_seq_type;

    // one-hot cause flags for the reset_cause_register
    function automatic logic [7:0] rsc_cause_flags(input rsc_cause_type cause);
        logic [7:0] f;
        f = FLAGS_RESET;
        case (cause)
            CAUSE_POWER: f[RCR_POWER_BIT] = 1'b1;
            CAUSE_PIN:   f[RCR_PIN_BIT]   = 1'b1;
            CAUSE_MCD:   f[RCR_MCD_BIT]   = 1'b1;
            CAUSE_COMP:  f[RCR_COMP_BIT]  = 1'b1;
            CAUSE_WDT:   f[RCR_WDT_BIT]   = 1'b1;
            CAUSE_FLASH: f[RCR_FLASH_BIT] = 1'b1;
            CAUSE_SOFT:  f[RCR_SOFT_BIT]  = 1'b1;
            default:     f = FLAGS_RESET;
        endcase
        return f;
    endfunction

endpackage

// [rsc_mcd_if.sv]
// interface between the controller and its missing clock detector.
// assumes clk_level is already synchronised to the controller clock.
`timescale 1ns/1ps
`default_nettype none
interface rsc_mcd_if;
    logic enable;
    logic clk_level;
    logic timeout;
    modport ctrl (output enable, output clk_level, input timeout);
    modport det  (input enable, input clk_level, output timeout);
endinterface
`default_nettype wire

// [rsc_mcd.sv]
// missing clock detector: one-shot retriggered by every level change of the
// monitored system clock. assumes a free-running i_clk faster than the timeout.
`timescale 1ns/1ps
`default_nettype none
module rsc_mcd #(
    parameter int TIMEOUT_CYCLES = rsc_pkg::MCD_TIMEOUT_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    rsc_mcd_if.det    mcd
);
    import rsc_pkg::*;

    localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(TIMEOUT_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);

    logic             prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic             timeout_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= mcd.clk_level;
        end
    end

    // a stuck high or low clock lets the count run out
    always_ff @(posedge i_clk) begin
        if (i_reset || !mcd.enable || (mcd.clk_level != prev_q)) begin
            cnt_q     <= CNT_ZERO;
            timeout_q <= 1'b0;
        end else if (cnt_q >= CNT_LIMIT) begin
            cnt_q     <= CNT_ZERO;
            timeout_q <= 1'b1; // see RQ7
        end else begin
            cnt_q     <= cnt_q + CNT_ONE;
            timeout_q <= 1'b0;
        end
    end

    assign mcd.timeout = timeout_q;

endmodule
`default_nettype wire

// [rsc_reset_source_controller.sv]
// reset source controller: supply monitor control, reset cause register and
// the system reset sequencer for every reset source.
// assumes a free-running 20 MHz I_CLK, I_RESET as the power-on reset, and
// same-clock flash and watchdog strobes; pins and analog levels are async.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: monitor on/off by its enable bit; resets only if also selected as source.
// RQ2: monitor control bit 6 reads live supply status, 1 when above threshold.
// RQ3: monitor control bit 5 picks high or low threshold, resets to 0.
// RQ4: monitor control bits 4 to 0 read zero, writes ignored.
// RQ5: software waits for monitor to settle before selecting it.
// RQ6: low reset pin resets the device; pin cause flag set on release.
// RQ7: missing clock one-shot times out on a stuck clock and resets.
// RQ8: cause bit 2 reads 1 only after a missing clock reset.
// RQ9: writing cause bit 2 enables or disables the missing clock detector.
// RQ10: only power and monitor resets drive the reset pin.
// RQ11: cause bit 5 enables comparator reset while plus input below minus.
// RQ12: cause bit 5 reads 1 only after a comparator reset.
// RQ13: software lets the comparator settle before enabling it as source.
// RQ14: after any reset the watchdog is enabled, ticking at clock over twelve.
// RQ15: watchdog timeout resets the device and sets its cause flag.
// RQ16: enabled flash write or erase at or above reserved base resets.
// RQ17: code read or branch fetch at or above reserved base resets.
// RQ18: secured access or access without high selected monitor resets.
// RQ19: flash error reset sets cause bit 6.
// RQ20: writing cause bit 4 forces a reset, bit reads 1 afterwards.
// RQ21: power-on or monitor reset sets cause bit 1 on release.
// RQ22: only power-on enables the monitor; other resets keep its state.
// RQ23: new reset keeps only its own cause flag; enables are kept.
module rsc_reset_source_controller #(
    parameter int                     FLASH_ADDR_W  = 16,
    parameter logic [FLASH_ADDR_W-1:0] RESERVED_BASE = 16'hF800,
    parameter int                     RESET_HOLD    = rsc_pkg::RESET_HOLD_CYCLES,
    parameter int                     MCD_TIMEOUT   = rsc_pkg::MCD_TIMEOUT_CYCLES
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET,
    input  wire logic [7:0]              I_SFR_ADDR,
    input  wire logic [7:0]              I_SFR_WDATA,
    input  wire logic                    I_SFR_WE,
    input  wire logic                    I_SFR_RE,
    output var  logic [7:0]              O_SFR_RDATA,
    input  wire logic                    I_RST_PIN_N,
    output var  logic                    O_RST_PIN_OUT,
    output var  logic                    O_RST_PIN_OE,
    input  wire logic                    I_SUPPLY_ABOVE,
    output var  logic                    O_MONITOR_ON,
    output var  logic                    O_THRESHOLD_HIGH,
    input  wire logic                    I_COMP_ABOVE,
    input  wire logic                    I_SYSTEM_CLOCK_SIGNAL_MON,
    input  wire logic                    I_WDT_TIMEOUT,
    input  wire logic                    I_WDT_EN_WR,
    input  wire logic                    I_WDT_EN_DATA,
    output var  logic                    O_WDT_ENABLE,
    output var  logic                    O_WDT_TICK,
    input  wire logic                    I_FLASH_WR,
    input  wire logic                    I_PROGRAM_STORE_WRITE_ENABLE,
    input  wire logic                    I_CODE_READ,
    input  wire logic                    I_BRANCH_FETCH,
    input  wire logic                    I_FLASH_SEC_BLOCK,
    input  wire logic [FLASH_ADDR_W-1:0] I_FLASH_ADDR,
    output var  logic                    O_SYS_RESET
);
    import rsc_pkg::*;

    localparam int HOLD_W = $clog2(RESET_HOLD + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESET_HOLD);
    localparam logic [HOLD_W-1:0] HOLD_ONE  = HOLD_W'(1);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = HOLD_W'(0);
    localparam int DIV_W = $clog2(WDT_DIVIDE);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(WDT_DIVIDE - 1);
    localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);
    localparam logic [DIV_W-1:0] DIV_ZERO = DIV_W'(0);

    // synchroniser lanes
    localparam int SY_PIN    = 0;
    localparam int SY_SUPPLY = 1;
    localparam int SY_COMP   = 2;
    localparam int SY_SYSTEM_CLOCK_SIGNAL = 3;
    localparam logic [3:0] SYNC_RESET = 4'h7;

    logic [3:0]        sync1_q;
    logic [3:0]        sync2_q;
    rsc_seq_type       state_q;
    rsc_cause_type     cause_q;
    rsc_cause_type     new_cause;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic              sys_reset_q;
    logic              pin_drive_q;
    logic [1:0]        drv_q;
    logic [7:0]        flags_q;
    logic              monitor_on_q;
    logic              level_q;
    logic              monitor_sel_q;
    logic              comp_en_q;
    logic              mcd_en_q;
    logic              wdt_en_q;
    logic [DIV_W-1:0]  div_q;
    logic              tick_q;
    logic [7:0]        rdata_q;
    logic              sfr_open;
    logic              wr_smc;
    logic              wr_rcr;
    logic              pin_low;
    logic              monitor_low;
    logic              comp_low;
    logic              soft_req;
    logic              wdt_req;
    logic              flash_access;
    logic              flash_high;
    logic              flash_err;
    logic              level_active;
    rsc_mcd_if         mcd_bus ();

    // two-flop synchronisers for pins and analog outputs
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end else begin
            sync1_q <= {I_SYSTEM_CLOCK_SIGNAL_MON, I_COMP_ABOVE, I_SUPPLY_ABOVE, I_RST_PIN_N};
            sync2_q <= sync1_q;
        end
    end

    // register port is closed while the system is held in reset
    assign sfr_open = !sys_reset_q;
    assign wr_smc   = sfr_open && I_SFR_WE && (I_SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR);
    assign wr_rcr   = sfr_open && I_SFR_WE && (I_SFR_ADDR == RESET_CAUSE_REGISTER_ADDR);

    // our own drive of the pin is not mistaken for an external reset
    assign pin_low     = !sync2_q[SY_PIN] && !pin_drive_q && !(|drv_q);             // see RQ6
    assign monitor_low = monitor_on_q && monitor_sel_q && !sync2_q[SY_SUPPLY];     // see RQ1
    assign comp_low    = comp_en_q && !sync2_q[SY_COMP];                           // see RQ11
    assign soft_req    = wr_rcr && I_SFR_WDATA[RCR_SOFT_BIT];                      // see RQ20
    assign wdt_req     = wdt_en_q && I_WDT_TIMEOUT;                                // see RQ15

    assign flash_access = (I_FLASH_WR && I_PROGRAM_STORE_WRITE_ENABLE) || I_CODE_READ;
    assign flash_high   = (I_FLASH_ADDR >= RESERVED_BASE);
    always_comb begin
        flash_err = 1'b0;
        if (I_FLASH_WR && I_PROGRAM_STORE_WRITE_ENABLE && flash_high) begin
            flash_err = 1'b1; // see RQ16
        end
        if ((I_CODE_READ || I_BRANCH_FETCH) && flash_high) begin
            flash_err = 1'b1; // see RQ17
        end
        if (flash_access && (I_FLASH_SEC_BLOCK || !(monitor_on_q && level_q && monitor_sel_q))) begin
            flash_err = 1'b1; // see RQ18
        end
    end

    // one cause per reset, highest priority first
    always_comb begin
        new_cause = CAUSE_NONE;
        if (monitor_low) begin
            new_cause = CAUSE_POWER;
        end else if (pin_low) begin
            new_cause = CAUSE_PIN;
        end else if (mcd_bus.timeout) begin
            new_cause = CAUSE_MCD;
        end else if (comp_low) begin
            new_cause = CAUSE_COMP;
        end else if (wdt_req) begin
            new_cause = CAUSE_WDT;
        end else if (sfr_open && flash_err) begin
            new_cause = CAUSE_FLASH;
        end else if (soft_req) begin
            new_cause = CAUSE_SOFT;
        end
    end

    // level sources keep the system in reset while their condition lasts
    always_comb begin
        case (cause_q)
            CAUSE_POWER: level_active = monitor_low;
            CAUSE_PIN:   level_active = !sync2_q[SY_PIN];
            CAUSE_COMP:  level_active = comp_low;
            default:     level_active = 1'b0;
        endcase
    end

    // reset sequencer
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_q     <= SEQ_HOLD;
            cause_q     <= CAUSE_POWER;
            hold_cnt_q  <= HOLD_LOAD;
            sys_reset_q <= 1'b1;
            pin_drive_q <= 1'b1;
        end else begin
            case (state_q)
                SEQ_RUN: begin
                    if (new_cause != CAUSE_NONE) begin
                        state_q     <= SEQ_HOLD;
                        cause_q     <= new_cause;
                        hold_cnt_q  <= HOLD_LOAD;
                        sys_reset_q <= 1'b1;                          // see RQ7
                        pin_drive_q <= (new_cause == CAUSE_POWER);    // see RQ10
                    end
                end
                SEQ_HOLD: begin
                    if (level_active) begin
                        hold_cnt_q <= HOLD_LOAD;
                    end else if (hold_cnt_q != HOLD_ZERO) begin
                        hold_cnt_q <= hold_cnt_q - HOLD_ONE;
                    end else begin
                        state_q     <= SEQ_RUN;
                        sys_reset_q <= 1'b0;
                        pin_drive_q <= 1'b0;
                    end
                end
                default: begin
                    state_q     <= SEQ_HOLD;
                    hold_cnt_q  <= HOLD_LOAD;
                    sys_reset_q <= 1'b1;
                    pin_drive_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        drv_q <= {drv_q[0], pin_drive_q};
    end

    // cause flags are replaced as the system leaves reset
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            flags_q <= FLAGS_RESET;
        end else if ((state_q == SEQ_HOLD) && !level_active && (hold_cnt_q == HOLD_ZERO)) begin
            flags_q <= rsc_cause_flags(cause_q); // see RQ6 RQ8 RQ12 RQ19 RQ20 RQ21 RQ23
        end
    end

    // supply monitor enable survives every reset but power-on
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            monitor_on_q <= MONITOR_ON_RESET;           // see RQ22
        end else if (wr_smc) begin
            monitor_on_q <= I_SFR_WDATA[SMC_ON_BIT];    // see RQ1
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET || sys_reset_q) begin
            level_q <= LEVEL_RESET;                     // see RQ3
        end else if (wr_smc) begin
            level_q <= I_SFR_WDATA[SMC_LEVEL_BIT];
        end
    end

    // source enables share the cause register address and are write-only
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            monitor_sel_q <= ENABLE_RESET;
            comp_en_q     <= ENABLE_RESET;
            mcd_en_q      <= ENABLE_RESET;
        end else if (wr_rcr) begin
            monitor_sel_q <= I_SFR_WDATA[RCR_POWER_BIT];
            comp_en_q     <= I_SFR_WDATA[RCR_COMP_BIT];  // see RQ11
            mcd_en_q      <= I_SFR_WDATA[RCR_MCD_BIT];   // see RQ9
        end
    end

    // watchdog enable and its divide-by-twelve clock
    always_ff @(posedge I_CLK) begin
        if (I_RESET || sys_reset_q) begin
            wdt_en_q <= WDT_EN_RESET;                   // see RQ14
        end else if (I_WDT_EN_WR) begin
            wdt_en_q <= I_WDT_EN_DATA;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET || sys_reset_q || !wdt_en_q) begin
            div_q  <= DIV_ZERO;
            tick_q <= 1'b0;
        end else if (div_q == DIV_LAST) begin
            div_q  <= DIV_ZERO;
            tick_q <= 1'b1;                             // see RQ14
        end else begin
            div_q  <= div_q + DIV_ONE;
            tick_q <= 1'b0;
        end
    end

    // read data, registered one cycle after the read strobe
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rdata_q <= RDATA_RESET;
        end else if (sfr_open && I_SFR_RE) begin
            case (I_SFR_ADDR)
                SUPPLY_MONITOR_CONTROL_ADDR:
                    rdata_q <= {monitor_on_q, sync2_q[SY_SUPPLY], level_q, SMC_UNUSED_READ}; // see RQ2 RQ4
                RESET_CAUSE_REGISTER_ADDR:
                    rdata_q <= flags_q;
                default:
                    rdata_q <= RDATA_RESET;
            endcase
        end
    end

    assign mcd_bus.enable    = mcd_en_q && !sys_reset_q;
    assign mcd_bus.clk_level = sync2_q[SY_SYSTEM_CLOCK_SIGNAL];

    rsc_mcd #(
        .TIMEOUT_CYCLES (MCD_TIMEOUT)
    ) u_mcd (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .mcd     (mcd_bus.det)
    );

    assign O_SFR_RDATA      = rdata_q;
    assign O_RST_PIN_OUT    = 1'b0 & pin_drive_q;
    assign O_RST_PIN_OE     = pin_drive_q;
    assign O_MONITOR_ON     = monitor_on_q;
    assign O_THRESHOLD_HIGH = level_q;
    assign O_WDT_ENABLE     = wdt_en_q;
    assign O_WDT_TICK       = tick_q;
    assign O_SYS_RESET      = sys_reset_q;

endmodule
`default_nettype wire

// [rsc_props.sv]
// concurrent checks on the reset source controller top ports
// assumes one clock domain and a synchronous active-high I_RESET
`timescale 1ns/1ps
`default_nettype none
module rsc_props
    import rsc_pkg::*;
#(
    parameter int                      FLASH_ADDR_W  = 16,
    parameter logic [FLASH_ADDR_W-1:0] RESERVED_BASE = 16'hF800
) (
    input wire logic                    I_CLK,
    input wire logic                    I_RESET,
    input wire logic [7:0]              I_SFR_ADDR,
    input wire logic [7:0]              I_SFR_WDATA,
    input wire logic                    I_SFR_WE,
    input wire logic                    I_SFR_RE,
    input wire logic [7:0]              O_SFR_RDATA,
    input wire logic                    I_RST_PIN_N,
    input wire logic                    O_RST_PIN_OUT,
    input wire logic                    O_RST_PIN_OE,
    input wire logic                    O_MONITOR_ON,
    input wire logic                    O_THRESHOLD_HIGH,
    input wire logic                    I_WDT_TIMEOUT,
    input wire logic                    O_WDT_ENABLE,
    input wire logic                    O_WDT_TICK,
    input wire logic                    I_FLASH_WR,
    input wire logic                    I_PROGRAM_STORE_WRITE_ENABLE,
    input wire logic [FLASH_ADDR_W-1:0] I_FLASH_ADDR,
    input wire logic                    O_SYS_RESET
);
    logic soft_wr;
    logic flash_bad;
    assign soft_wr   = I_SFR_WE && !O_SYS_RESET && I_SFR_ADDR == RESET_CAUSE_REGISTER_ADDR && I_SFR_WDATA[RCR_SOFT_BIT];
    assign flash_bad = I_FLASH_WR && I_PROGRAM_STORE_WRITE_ENABLE && I_FLASH_ADDR >= RESERVED_BASE && !O_SYS_RESET;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // a read taken, not followed by another read
    sequence rd_smc;
        I_SFR_RE && !O_SYS_RESET && I_SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR ##1 !I_SFR_RE;
    endsequence
    sequence rd_rcr;
        I_SFR_RE && !O_SYS_RESET && I_SFR_ADDR == RESET_CAUSE_REGISTER_ADDR ##1 !I_SFR_RE;
    endsequence
    sequence pin_held;
        !I_RST_PIN_N && !O_SYS_RESET ##1 !I_RST_PIN_N [*2];
    endsequence
    AST_SMC_ZERO: assert property (rd_smc |=> O_SFR_RDATA[4:0] == SMC_UNUSED_READ)
        else $error("monitor control low bits not zero");
    AST_SMC_FIELDS: assert property (rd_smc |=> O_SFR_RDATA[7] == $past(O_MONITOR_ON, 2) && O_SFR_RDATA[5] == $past(O_THRESHOLD_HIGH, 2))
        else $error("monitor control fields read wrong");
    AST_RCR_ONE: assert property (rd_rcr |=> !O_SFR_RDATA[7] && $onehot(O_SFR_RDATA[6:0]))
        else $error("cause register not one-hot");
    AST_PIN_RST: assert property (pin_held |-> ##[0:1] O_SYS_RESET)
        else $error("pin low did not reset");
    AST_PIN_DRIVE: assert property (O_RST_PIN_OE |-> O_SYS_RESET && !O_RST_PIN_OUT)
        else $error("pin driven outside reset");
    AST_SOFT_RST: assert property (soft_wr |=> O_SYS_RESET && !O_RST_PIN_OE ##1 O_SYS_RESET)
        else $error("soft reset wrong");
    AST_FLASH_WR: assert property (flash_bad |=> O_SYS_RESET)
        else $error("flash write error no reset");
    AST_WDT_RST: assert property (I_WDT_TIMEOUT && O_WDT_ENABLE && !O_SYS_RESET |=> O_SYS_RESET)
        else $error("watchdog overflow no reset");
    AST_WDT_UP: assert property ($fell(O_SYS_RESET) |-> O_WDT_ENABLE)
        else $error("watchdog not enabled after reset");
    AST_WDT_TICK: assert property (O_WDT_TICK |=> !O_WDT_TICK [*8])
        else $error("watchdog tick too early");
    AST_MON_KEEP: assert property (O_SYS_RESET && $past(O_SYS_RESET) |-> $stable(O_MONITOR_ON))
        else $error("monitor state changed in reset");
    AST_LVL_CLR: assert property (O_SYS_RESET && $past(O_SYS_RESET) |-> !O_THRESHOLD_HIGH)
        else $error("threshold not cleared by reset");
endmodule
`default_nettype wire

// [rsc_pin_partner.sv]
// external reset circuitry on the pulled-up reset pin
// assumes the device drives the pin only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_partner (
    input  wire logic i_hold_low,
    input  wire logic i_dev_oe,
    input  wire logic i_dev_out,
    output var  logic o_pin_n
);
    // pull-up wins when nobody drives
    assign o_pin_n = (i_dev_oe ? i_dev_out : 1'b1) & !i_hold_low;
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the reset source controller and its pin partner
// assumes short hold and detector counts so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rsc_pkg::*;
    localparam int HOLD = 2;
    localparam int MCDT = 16;
    logic        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, sup = 1'b1, comp = 1'b1, smon = 1'b0;
    logic        wto = 1'b0, wen_wr = 1'b0, wen_d = 1'b1;
    logic        hold_low = 1'b0, mcd_run = 1'b1;
    logic        pin_n, oe, pout, mon, thr, wdt_en, tick, sysrst;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
    logic [20:0] fl = '0, tbl [5];
    bit          mon_m = 1'b1, lvl_m = 1'b0;
    int          error_cnt = 0, compares = 0, i;
    int          exp_q [$];

    rsc_reset_source_controller #(.RESET_HOLD(HOLD), .MCD_TIMEOUT(MCDT)) rsc_reset_source_controller_i (
        .I_CLK(clk), .I_RESET(rst), .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata), .I_SFR_WE(we),
        .I_SFR_RE(re), .O_SFR_RDATA(rdata), .I_RST_PIN_N(pin_n), .O_RST_PIN_OUT(pout),
        .O_RST_PIN_OE(oe), .I_SUPPLY_ABOVE(sup), .O_MONITOR_ON(mon), .O_THRESHOLD_HIGH(thr),
        .I_COMP_ABOVE(comp), .I_SYSTEM_CLOCK_SIGNAL_MON(smon), .I_WDT_TIMEOUT(wto), .I_WDT_EN_WR(wen_wr),
        .I_WDT_EN_DATA(wen_d), .O_WDT_ENABLE(wdt_en), .O_WDT_TICK(tick), .I_FLASH_WR(fl[20]),
        .I_PROGRAM_STORE_WRITE_ENABLE(fl[19]), .I_CODE_READ(fl[18]), .I_BRANCH_FETCH(fl[17]),
        .I_FLASH_SEC_BLOCK(fl[16]), .I_FLASH_ADDR(fl[15:0]), .O_SYS_RESET(sysrst));
    rsc_pin_partner rsc_pin_partner_i (.i_hold_low(hold_low), .i_dev_oe(oe), .i_dev_out(pout), .o_pin_n(pin_n));

    always #25 clk = ~clk;
    always @(negedge clk) if (mcd_run) smon <= ~smon;

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) begin addr = a; wdata = d; we = 1'b1; end
        @(negedge clk) we = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(negedge clk) begin addr = a; re = 1'b1; end
        @(negedge clk) re = 1'b0;
        @(negedge clk);
    endtask
    task chk_smc;
        rd(SUPPLY_MONITOR_CONTROL_ADDR);
        chk(rdata, {mon_m, sup, lvl_m, 5'h00});
    endtask
    // waits out one reset, then compares the cause with the model
    task rst_seen;
        int n;
        n = 0;
        while (sysrst !== 1'b1 && n < 40) begin @(negedge clk); n++; end
        mcd_run = 1'b1;
        chk({7'h00, sysrst}, 8'h01);
        n = 0;
        while (sysrst !== 1'b0 && n < 200) begin @(negedge clk); n++; end
        chk({7'h00, sysrst}, 8'h00);
        lvl_m = 1'b0;
        rd(RESET_CAUSE_REGISTER_ADDR);
        chk(rdata, 8'(exp_q.pop_front()));
    endtask
    task no_rst(input int cyc);
        repeat (cyc) @(negedge clk);
        chk({7'h00, sysrst}, 8'h00);
    endtask
    task pulse_wto;
        @(negedge clk) wto = 1'b1;
        @(negedge clk) wto = 1'b0;
    endtask

    initial begin
        #(50 * 5000);
        error_cnt++;
        end_of_test;
    end

    initial begin
        void'($urandom(91));
        tbl[0] = {5'b11000, 16'hF800};
        tbl[1] = {5'b00100, 16'hFFFF};
        tbl[2] = {5'b00010, 16'hF800};
        tbl[3] = {5'b00101, 16'h0100};
        tbl[4] = {5'b00100, 16'h0100};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        exp_q.push_back(8'h02);
        rst_seen;
        chk_smc;
        for (i = 0; i < 6; i++) begin
            v = 8'($urandom);
            sup = v[0];
            wr(SUPPLY_MONITOR_CONTROL_ADDR, v);
            mon_m = v[7];
            lvl_m = v[5];
            repeat (3) @(negedge clk);
            chk_smc;
            no_rst(1);
        end
        sup = 1'b1;
        wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h20);
        mon_m = 1'b0;
        lvl_m = 1'b1;
        @(negedge clk) begin wen_wr = 1'b1; wen_d = 1'b0; end
        @(negedge clk) wen_wr = 1'b0;
        @(negedge clk) chk({7'h00, wdt_en}, 8'h00);
        pulse_wto;
        no_rst(3);
        exp_q.push_back(8'h10);
        wr(RESET_CAUSE_REGISTER_ADDR, 8'h10);
        rst_seen;
        chk_smc;
        chk({7'h00, wdt_en}, 8'h01);
        wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h80);
        mon_m = 1'b1;
        exp_q.push_back(8'h08);
        pulse_wto;
        rst_seen;
        exp_q.push_back(8'h01);
        hold_low = 1'b1;
        repeat (5) @(negedge clk);
        hold_low = 1'b0;
        rst_seen;
        wr(RESET_CAUSE_REGISTER_ADDR, 8'h04);
        exp_q.push_back(8'h04);
        mcd_run = 1'b0;
        rst_seen;
        wr(RESET_CAUSE_REGISTER_ADDR, 8'h00);
        mcd_run = 1'b0;
        no_rst(40);
        mcd_run = 1'b1;
        wr(RESET_CAUSE_REGISTER_ADDR, 8'h20);
        exp_q.push_back(8'h20);
        @(negedge clk) comp = 1'b0;
        repeat (4) @(negedge clk);
        comp = 1'b1;
        rst_seen;
        wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'hA0);
        repeat (5) @(negedge clk);
        wr(RESET_CAUSE_REGISTER_ADDR, 8'h02);
        @(negedge clk) fl = {5'b11000, 16'h0100};
        @(negedge clk) fl = {5'b00010, 16'h0100};
        @(negedge clk) fl[20:16] = 5'b00000;
        no_rst(3);
        for (i = 0; i < 5; i++) begin
            exp_q.push_back(8'h40);
            @(negedge clk) fl = tbl[i];
            @(negedge clk) fl[20:16] = 5'b00000;
            rst_seen;
        end
        end_of_test;
    end
endmodule

bind rsc_reset_source_controller rsc_props #(.FLASH_ADDR_W(FLASH_ADDR_W), .RESERVED_BASE(RESERVED_BASE)) rsc_props_i (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WDATA(I_SFR_WDATA),
    .I_SFR_WE(I_SFR_WE), .I_SFR_RE(I_SFR_RE), .O_SFR_RDATA(O_SFR_RDATA), .I_RST_PIN_N(I_RST_PIN_N),
    .O_RST_PIN_OUT(O_RST_PIN_OUT), .O_RST_PIN_OE(O_RST_PIN_OE), .O_MONITOR_ON(O_MONITOR_ON),
    .O_THRESHOLD_HIGH(O_THRESHOLD_HIGH), .I_WDT_TIMEOUT(I_WDT_TIMEOUT), .O_WDT_ENABLE(O_WDT_ENABLE),
    .O_WDT_TICK(O_WDT_TICK), .I_FLASH_WR(I_FLASH_WR),
    .I_PROGRAM_STORE_WRITE_ENABLE(I_PROGRAM_STORE_WRITE_ENABLE), .I_FLASH_ADDR(I_FLASH_ADDR),
    .O_SYS_RESET(O_SYS_RESET));
`default_nettype wire
